// ==== test_video_transition_keying_control.sv ====
// Self-checking bench for the mix-effects stage
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module test_video_transition_keying_control;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, frame_start = 1'b0, in_valid, in_ready, out_valid, out_ready;
  logic take = 1'b0, lever_en = 1'b0, next_bkg = 1'b1, preset_ld = 1'b0, preset_black = 1'b0, lookahead = 1'b0;
  logic ftb_go = 1'b0, stall = 1'b0, trans_busy, on_black;
  logic [31:0] src_pix, key_fill = 32'h0, key_cut = 32'h0, key_clip = {4{8'h01}}, kpat_lvl = 32'h0, kbox_lvl = 32'h0;
  logic [31:0] key_rate = {4{8'h01}}, word = {8'h40, 8'h80, 8'hc0, 8'h10};
  logic [35:0] key_opac = {4{9'h100}};
  logic [8:0]  lever_pos = 9'h000, ftb_level;
  logic [7:0]  pix_x = 8'h00, pix_y = 8'h00, pgm_pix, pvw_pix, aux_pix, main_rate = 8'h01, ftb_rate = 8'h02;
  logic [7:0]  next_prio = 8'he4, kmask_mode = 8'h00, g, v, a;
  logic [3:0]  next_key_on = 4'h1, key_mix_go = 4'h0, self_key = 4'h0, key_on;
  logic [1:0]  wipe_pat1 = 2'h0, wipe_pat2 = 2'h1, wipe_comb = 2'h0, preset_sel = 2'h0, bus_a_sel, bus_b_sel;
  vtk_pkg::vtk_trans_t trans_type = vtk_pkg::TT_CUT;
  vtk_pkg::vtk_opt_t   opt_req = vtk_pkg::OPT_NONE, opt_mode;
  int n_req = 0, n_acc, n_pop, n_mismatch = 0, compares = 0, b;

  always #2 clk = ~clk;

  vtk_me_stage dut (.clk, .reset, .ce, .frame_start, .in_valid, .in_ready, .src_pix, .pix_x, .pix_y, .key_fill,
    .key_cut, .out_valid, .out_ready, .pgm_pix, .pvw_pix, .aux_pix, .trans_type, .take, .lever_en, .lever_pos,
    .main_rate, .wipe_pat1, .wipe_pat2, .wipe_comb, .next_bkg, .next_key_on, .next_prio, .preset_ld, .preset_sel,
    .preset_black, .lookahead, .key_mix_go, .key_rate, .self_key, .key_clip, .key_opac, .kmask_mode, .kpat_lvl,
    .kbox_lvl, .opt_req, .ftb_go, .ftb_rate, .trans_busy, .on_black, .opt_mode, .ftb_level, .bus_a_sel,
    .bus_b_sel, .key_on);
  vtk_pix_partner model (.clk, .reset, .n_req, .word, .stall, .in_ready, .out_valid, .in_valid, .src_pix,
    .out_ready, .n_acc, .n_pop);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic frame();
    @(posedge clk) frame_start <= 1'b1;
    @(posedge clk) frame_start <= 1'b0;
    @(negedge clk);
  endtask : frame
  task automatic take_it();
    @(posedge clk) take <= 1'b1;
    @(posedge clk) take <= 1'b0;
    @(negedge clk);
  endtask : take_it
  task automatic get_pix();
    int i;
    @(posedge clk) n_req <= n_req + 1;
    i = 0;
    do begin @(negedge clk); i++; end while (out_valid !== 1'b1 && i < 50);
    if (out_valid !== 1'b1) n_mismatch++;
    g = pgm_pix;
    v = pvw_pix;
    a = aux_pix;
    @(negedge clk);
  endtask : get_pix

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_cut_swap();
    @(posedge clk) preset_ld <= 1'b1;
    preset_sel <= 2'h2;
    @(posedge clk) preset_ld <= 1'b0;
    @(negedge clk);
    `CHK("bus_b early", 2'h0, bus_b_sel)
    frame();
    `CHK("bus_b preset", 2'h2, bus_b_sel)
    take_it();
    `CHK("busy cut", 1'b1, trans_busy)
    frame();
    `CHK("busy end", 1'b0, trans_busy)
    `CHK("bus_a", 2'h2, bus_a_sel)
    `CHK("bus_b", 2'h0, bus_b_sel)
    `CHK("key_on", 4'h1, key_on)
    get_pix();
    `CHK("pgm", 8'h80, g)
    `CHK("pvw raw", 8'h10, v)
    `CHK("aux bus b", 8'h10, a)
  endtask : t_cut_swap
  task automatic t_additive();
    @(posedge clk) preset_ld <= 1'b1;
    preset_sel <= 2'h1;
    trans_type <= vtk_pkg::TT_ADD;
    main_rate <= 8'h02;
    @(posedge clk) preset_ld <= 1'b0;
    frame();
    take_it();
    frame();
    get_pix();
    `CHK("add mid", 8'hff, g)
    frame();
    `CHK("add end", 1'b0, trans_busy)
    get_pix();
    `CHK("add after", 8'hc0, g)
  endtask : t_additive
  task automatic t_mix_rate();
    @(posedge clk) trans_type <= vtk_pkg::TT_MIX;
    main_rate <= 8'h03;
    next_bkg <= 1'b0;
    lookahead <= 1'b1;
    take_it();
    get_pix();
    `CHK("lookahead", 8'hc0, v)
    repeat (2) frame();
    `CHK("mix busy", 1'b1, trans_busy)
    frame();
    `CHK("mix done", 1'b0, trans_busy)
    `CHK("no swap", 2'h1, bus_a_sel)
  endtask : t_mix_rate
  task automatic t_preset_black();
    @(posedge clk) preset_black <= 1'b1;
    trans_type <= vtk_pkg::TT_CUT;
    take_it();
    frame();
    `CHK("on_black", 1'b1, on_black)
    get_pix();
    `CHK("black pgm", 8'h00, g)
    @(posedge clk) preset_black <= 1'b0;
    take_it();
    frame();
    `CHK("off_black", 1'b0, on_black)
  endtask : t_preset_black
  task automatic t_buffer();
    b = n_acc;
    @(posedge clk) stall <= 1'b1;
    n_req <= n_req + 5;
    repeat (10) @(negedge clk);
    `CHK("held", b + 2, n_acc)
    `CHK("refuse", 1'b0, in_ready)
    @(posedge clk) stall <= 1'b0;
    repeat (20) @(negedge clk);
    `CHK("drained", b + 5, n_pop)
    `CHK("empty", 1'b0, out_valid)
  endtask : t_buffer
  task automatic t_option();
    @(posedge clk) opt_req <= vtk_pkg::OPT_BAD;
    frame();
    `CHK("opt bad", vtk_pkg::OPT_NONE, opt_mode)
    @(posedge clk) opt_req <= vtk_pkg::OPT_DSTAGE;
    frame();
    `CHK("opt dsk", vtk_pkg::OPT_DSTAGE, opt_mode)
    @(posedge clk) ftb_go <= 1'b1;
    @(posedge clk) ftb_go <= 1'b0;
    repeat (2) frame();
    `CHK("ftb", vtk_pkg::POS_FULL, ftb_level)
    @(posedge clk) key_mix_go <= 4'h3;
    @(posedge clk) key_mix_go <= 4'h0;
    frame();
    `CHK("key mix", 4'h2, key_on)
  endtask : t_option
  task automatic t_half();
    @(posedge clk) opt_req <= vtk_pkg::OPT_HALF;
    trans_type <= vtk_pkg::TT_WIPE;
    self_key <= 4'h2;
    key_fill <= 32'h0000_5a00;
    frame();
    `CHK("opt half", vtk_pkg::OPT_HALF, opt_mode)
    @(posedge clk) lever_en <= 1'b1;
    lever_pos <= 9'h080;
    frame();
    `CHK("lever busy", 1'b1, trans_busy)
    get_pix();
    `CHK("half aux", 8'h8d, a)
    `CHK("half pvw", 8'hc0, v)
    @(posedge clk) lever_pos <= 9'h100;
    frame();
    `CHK("lever end", 1'b0, trans_busy)
    `CHK("half keys", 4'h1, key_on)
  endtask : t_half

  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3) @(negedge clk);
    `CHK("ready in reset", 1'b0, in_ready)
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("key_on rst", 4'h0, key_on)
    t_cut_swap();
    t_additive();
    t_mix_rate();
    t_preset_black();
    t_buffer();
    t_option();
    t_half();
    wrap_up();
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule : test_video_transition_keying_control

// ==== vtk_me_stage.sv ====
// Mix-effects stage: transitions, stacks, keyers and output buffer
// Functional notes
// R1: Additive: raise new first, then lower old
// R2: Additive sum clipped at white
// R3: Two wipe systems, separately set, combinable
// R4: Each keyer has simple and box generator
// R5: Preset black is two separately taken transitions
// R6: Preset black blacks the whole picture
// R7: Fade to black at its own rate
// R8: Cut at frame boundary; mix/wipe timed or manual (with lever_en a cut blends by lever_pos like a mix)
// R9: Main transition uses one rate or lever
// R10: Each keyer has own rate and trigger
// R11: Background buses swap at transition end
// R12: Look-ahead preview shows the next stack
// R13: Next stack: keys, background, priority
// R14: Transitions blend whole composites
// R15: Keys stay fully keyed in both composites
// R16: Key-mixed keys fade alone, outside blend
// R17: Keys layered by priority over backgrounds
// R18: Priority change carried by the transition
// R19: Half stage: cuts and mixes, output routable
// R20: Downstream stage and half stage exclusive
// R21: Self key uses fill as cut
// R22: Luminance key hole from cut, fill shaped
// R23: Opacity lets background through the key
// R24: Position ramps per frame, ends on last
// R25: Bus selections change only at frame boundary
`timescale 1ns/1ps
module vtk_me_stage #(
  parameter int NKEY = vtk_pkg::NKEY,
  parameter int PW   = vtk_pkg::PIX_W,
  parameter int RW   = vtk_pkg::RATE_W
) (
  // Clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  // Frame timing
  input  wire logic                    frame_start,
  // Pixel input stream
  input  wire logic                    in_valid,
  output logic                         in_ready,
  input  wire logic [vtk_pkg::NSRC*PW-1:0] src_pix,
  input  wire logic [PW-1:0]           pix_x,
  input  wire logic [PW-1:0]           pix_y,
  input  wire logic [NKEY*PW-1:0]      key_fill,
  input  wire logic [NKEY*PW-1:0]      key_cut,
  // Pixel output stream
  output logic                         out_valid,
  input  wire logic                    out_ready,
  output logic [PW-1:0]                pgm_pix,
  output logic [PW-1:0]                pvw_pix,
  output logic [PW-1:0]                aux_pix,
  // Main transition
  input  wire vtk_pkg::vtk_trans_t     trans_type,
  input  wire logic                    take,
  input  wire logic                    lever_en,
  input  wire logic [8:0]              lever_pos,
  input  wire logic [RW-1:0]           main_rate,
  input  wire logic [1:0]              wipe_pat1,
  input  wire logic [1:0]              wipe_pat2,
  input  wire logic [1:0]              wipe_comb,
  // Next stack and buses
  input  wire logic                    next_bkg,
  input  wire logic [NKEY-1:0]         next_key_on,
  input  wire logic [2*NKEY-1:0]       next_prio,
  input  wire logic                    preset_ld,
  input  wire logic [1:0]              preset_sel,
  input  wire logic                    preset_black,
  input  wire logic                    lookahead,
  // Keyers
  input  wire logic [NKEY-1:0]         key_mix_go,
  input  wire logic [NKEY*RW-1:0]      key_rate,
  input  wire logic [NKEY-1:0]         self_key,
  input  wire logic [NKEY*PW-1:0]      key_clip,
  input  wire logic [NKEY*9-1:0]       key_opac,
  input  wire logic [2*NKEY-1:0]       kmask_mode,
  input  wire logic [NKEY*PW-1:0]      kpat_lvl,
  input  wire logic [NKEY*PW-1:0]      kbox_lvl,
  // Option and fade to black
  input  wire vtk_pkg::vtk_opt_t       opt_req,
  input  wire logic                    ftb_go,
  input  wire logic [RW-1:0]           ftb_rate,
  // Status
  output logic                         trans_busy,
  output logic                         on_black,
  output vtk_pkg::vtk_opt_t            opt_mode,
  output logic [8:0]                   ftb_level,
  output logic [1:0]                   bus_a_sel,
  output logic [1:0]                   bus_b_sel,
  output logic [NKEY-1:0]              key_on
);

  localparam int         PSW   = vtk_pkg::POS_W;
  localparam logic [8:0] FULL  = vtk_pkg::POS_FULL;
  localparam logic [8:0] HALF  = vtk_pkg::POS_HALF;
  localparam logic [8:0] ZERO  = vtk_pkg::POS_ZERO;
  localparam logic [7:0] WHITE = vtk_pkg::PIX_WHITE;
  localparam logic [7:0] BLACK = vtk_pkg::PIX_BLACK;

  typedef struct packed {
    logic                busy;
    logic                lvr;
    logic                lhold;
    vtk_pkg::vtk_trans_t tt;
    logic [RW-1:0]       cnt;
    logic [PSW-1:0]      pos;
    vtk_pkg::vtk_pb_t    pb;
    logic [1:0]          sel_a;
    logic [1:0]          sel_b;
    logic                pend;
    logic [1:0]          pend_sel;
    logic                nbg;
    logic [NKEY-1:0]     non;
    logic [NKEY-1:0]     con;
    logic [2*NKEY-1:0]   nprio;
    logic [2*NKEY-1:0]   cprio;
    logic [NKEY-1:0]     kbusy;
    logic [NKEY-1:0]     kdir;
    logic [NKEY*RW-1:0]  kcnt;
    logic [NKEY*PSW-1:0] klvl;
    logic                fbusy;
    logic                fdir;
    logic [RW-1:0]       fcnt;
    logic [PSW-1:0]      fpos;
    vtk_pkg::vtk_opt_t   opt;
    logic [1:0]          bcnt;
    logic [3*PW-1:0]     h0;
    logic [3*PW-1:0]     h1;
    logic                ov;
    logic                rdy;
  } vtk_st_t;

  vtk_st_t             st_r;
  vtk_st_t             st_n;
  logic [PW-1:0]       src_a;
  logic [PW-1:0]       src_b;
  logic [PW-1:0]       nbg_pix;
  logic [NKEY*PSW-1:0] ka;
  logic [NKEY*PSW-1:0] kma;
  logic [PW-1:0]       cur_c;
  logic [PW-1:0]       nxt_c;
  logic [PW-1:0]       mixed;
  logic [PW-1:0]       layered;
  logic [PW-1:0]       pgm_c;
  logic [PW-1:0]       pvw_c;
  logic [PW-1:0]       aux_c;
  logic                w1;
  logic                w2;
  logic                wsel;
  logic [PSW-1:0]      ga;
  logic [PSW-1:0]      gb;
  logic [PW:0]         asum;
  logic                to_blk;
  logic                push;
  logic                pop;
  logic                start;
  logic                done;
  logic                fin;
  logic [RW-1:0]       cnt1;
  logic [PSW-1:0]      r;

  // ********************************
  // Arithmetic helpers
  // ********************************
  function automatic logic [PW-1:0] blend(input logic [PW-1:0] a, input logic [PW-1:0] b,
                                          input logic [PSW-1:0] f);
    logic [PW+9:0] t;
    t = a * (FULL - f) + b * f;
    return t[PW+7:8];
  endfunction : blend

  function automatic logic [PSW-1:0] mul9(input logic [PSW-1:0] a, input logic [PSW-1:0] b);
    logic [17:0] t;
    t = a * b;
    return t[16:8];
  endfunction : mul9

  // Position from a frame count; full once the count reaches the rate
  function automatic logic [PSW-1:0] ramp(input logic [RW-1:0] c, input logic [RW-1:0] rt);
    logic [RW+8:0] q;
    q = '0;
    if (rt == '0 || c >= rt) begin
      return FULL;
    end
    q = {1'h0, c, 8'h00} / {9'h000, rt};
    return q[PSW-1:0];
  endfunction : ramp

  function automatic logic shape(input logic [1:0] pat, input logic [PW-1:0] x,
                                 input logic [PW-1:0] y, input logic [PSW-1:0] lv);
    logic [PW:0] dx;
    logic [PW:0] dy;
    logic [PW:0] s;
    dx = x[PW-1] ? {1'h0, x} - {1'h0, vtk_pkg::PIX_MID} : {1'h0, vtk_pkg::PIX_MID} - {1'h0, x};
    dy = y[PW-1] ? {1'h0, y} - {1'h0, vtk_pkg::PIX_MID} : {1'h0, vtk_pkg::PIX_MID} - {1'h0, y};
    s  = {1'h0, x} + {1'h0, y};
    unique case (pat)
      vtk_pkg::WP_HORZ: return {1'h0, x} < lv;
      vtk_pkg::WP_VERT: return {1'h0, y} < lv;
      vtk_pkg::WP_BOX:  return {dx[PW-1:0], 1'h0} < lv && {dy[PW-1:0], 1'h0} < lv;
      vtk_pkg::WP_DIAG: return {1'h0, s[PW:1]} < lv;
    endcase
  endfunction : shape

  // Cut the hole, shape the fill with the same control, then sum
  function automatic logic [PW-1:0] keyin(input logic [PW-1:0] bg, input logic [PW-1:0] f,
                                          input logic [PSW-1:0] a);
    logic [PW:0] s;
    s = {1'h0, blend(bg, BLACK, a)} + {1'h0, blend(BLACK, f, a)}; // R22
    return s[PW] ? WHITE : s[PW-1:0];
  endfunction : keyin

  function automatic logic [PW-1:0] compose(input logic [PW-1:0] bg,
                                            input logic [NKEY*PSW-1:0] al,
                                            input logic [NKEY*PW-1:0] fl,
                                            input logic [NKEY-1:0] on,
                                            input logic [2*NKEY-1:0] pr);
    logic [PW-1:0] p;
    logic [1:0]    k;
    p = bg;
    for (int j = 0; j < NKEY; j++) begin
      k = pr[2*j+:2];
      if (on[k]) begin
        p = keyin(p, fl[k*PW+:PW], al[k*PSW+:PSW]); // R17
      end
    end
    return p;
  endfunction : compose

  // ********************************
  // Keyer control signals
  // ********************************
  for (genvar i = 0; i < NKEY; i++) begin : g_key
    logic [PW-1:0]  kc;
    logic [PSW-1:0] a0;
    logic [PSW-1:0] a1;
    logic [1:0]     md;
    logic           ms;
    logic           mb;
    assign kc = self_key[i] ? key_fill[i*PW+:PW] : key_cut[i*PW+:PW]; // R21
    assign a0 = (kc >= key_clip[i*PW+:PW]) ? FULL : ZERO; // R22
    assign md = kmask_mode[2*i+:2];
    assign ms = shape(vtk_pkg::WP_HORZ, pix_x, pix_y, {1'h0, kpat_lvl[i*PW+:PW]}); // R4
    assign mb = shape(vtk_pkg::WP_BOX, pix_x, pix_y, {1'h0, kbox_lvl[i*PW+:PW]}); // R4
    assign a1 = (md == vtk_pkg::MK_FRC_B && mb) ? FULL :
                ((md == vtk_pkg::MK_INH_S && ms) || (md == vtk_pkg::MK_INH_B && mb)) ? ZERO : a0;
    assign ka[i*PSW+:PSW]  = mul9(a1, key_opac[i*9+:9]); // R23
    assign kma[i*PSW+:PSW] = mul9(ka[i*PSW+:PSW], st_r.klvl[i*PSW+:PSW]); // R16
  end

  // ********************************
  // Pixel path
  // ********************************
  assign src_a   = src_pix[st_r.sel_a*PW+:PW];
  assign src_b   = src_pix[st_r.sel_b*PW+:PW];
  assign nbg_pix = (st_r.busy ? st_r.nbg : next_bkg) ? src_b : src_a;
  assign to_blk  = st_r.busy ? (st_r.pb == vtk_pkg::PB_TO) : (preset_black && st_r.pb == vtk_pkg::PB_OFF);

  always_comb begin
    cur_c = (st_r.pb == vtk_pkg::PB_HELD || st_r.pb == vtk_pkg::PB_FROM) ? BLACK : // R6
            compose(src_a, ka, key_fill, st_r.con & ~st_r.kbusy, st_r.cprio); // R15
    nxt_c = to_blk ? BLACK : // R5
            compose(nbg_pix, ka, key_fill, (st_r.busy ? st_r.non : next_key_on) & ~st_r.kbusy,
                    st_r.busy ? st_r.nprio : next_prio); // R13
    w1 = shape(wipe_pat1, pix_x, pix_y, st_r.pos); // R3
    w2 = shape(wipe_pat2, pix_x, pix_y, st_r.pos); // R3
    unique case (wipe_comb)
      vtk_pkg::WC_ONE: wsel = w1;
      vtk_pkg::WC_OR:  wsel = w1 | w2;
      vtk_pkg::WC_AND: wsel = w1 & w2;
      vtk_pkg::WC_XOR: wsel = w1 ^ w2;
    endcase
    ga    = (st_r.pos <= HALF) ? FULL : (FULL - st_r.pos) << 1; // R1
    gb    = (st_r.pos >= HALF) ? FULL : st_r.pos << 1; // R1
    asum  = {1'h0, blend(BLACK, cur_c, ga)} + {1'h0, blend(BLACK, nxt_c, gb)};
    mixed = cur_c;
    if (st_r.busy) begin
      unique case (st_r.tt)
        vtk_pkg::TT_CUT, vtk_pkg::TT_MIX: mixed = blend(cur_c, nxt_c, st_r.pos); // R14
        vtk_pkg::TT_ADD:  mixed = asum[PW] ? WHITE : asum[PW-1:0]; // R2
        vtk_pkg::TT_WIPE: mixed = wsel ? nxt_c : cur_c;
      endcase
    end
    layered = (st_r.pb == vtk_pkg::PB_HELD) ? mixed :
              compose(mixed, kma, key_fill, st_r.kbusy, st_r.cprio); // R16
    pgm_c = (st_r.opt == vtk_pkg::OPT_DSTAGE) ? blend(layered, BLACK, st_r.fpos) : layered; // R7
    pvw_c = lookahead ? nxt_c : src_b; // R12
    aux_c = (st_r.opt == vtk_pkg::OPT_HALF) ? layered : src_b; // R19
  end

  // ********************************
  // Control state
  // ********************************
  assign push = in_valid & st_r.rdy;
  assign pop  = st_r.ov & out_ready;

  always_comb begin
    st_n  = st_r;
    start = 1'h0;
    done  = 1'h0;
    fin   = 1'h0;
    cnt1  = '0;
    r     = '0;
    if (ce) begin
      if (pop) begin
        st_n.h0   = st_r.h1;
        st_n.bcnt = st_r.bcnt - 2'h1;
      end
      if (push) begin
        if (st_n.bcnt == 2'h0) begin
          st_n.h0 = {pgm_c, pvw_c, aux_c};
        end else begin
          st_n.h1 = {pgm_c, pvw_c, aux_c};
        end
        st_n.bcnt = st_n.bcnt + 2'h1;
      end
      st_n.ov  = st_n.bcnt != 2'h0;
      st_n.rdy = st_n.bcnt != vtk_pkg::BUF_DEPTH;
      if (lever_pos == ZERO) begin
        st_n.lhold = 1'h0;
      end
      start = !st_r.busy && (lever_en ? (frame_start && !st_r.lhold && lever_pos != ZERO) : take); // R9
      if (start) begin
        st_n.busy  = 1'h1;
        st_n.lvr   = lever_en;
        st_n.cnt   = '0;
        st_n.pos   = lever_en ? lever_pos : ZERO;
        st_n.tt    = (st_r.opt == vtk_pkg::OPT_HALF && trans_type[1]) ? vtk_pkg::TT_MIX : trans_type; // R19
        st_n.nbg   = next_bkg; // R13
        st_n.non   = next_key_on;
        st_n.nprio = next_prio;
        if (preset_black && st_r.pb == vtk_pkg::PB_OFF) begin
          st_n.pb = vtk_pkg::PB_TO; // R5
        end else if (st_r.pb == vtk_pkg::PB_HELD) begin
          st_n.pb = vtk_pkg::PB_FROM; // R5
        end
      end else if (frame_start && st_r.busy) begin
        if (st_r.lvr) begin
          done     = lever_pos >= FULL; // R9
          st_n.pos = done ? FULL : lever_pos;
        end else begin
          cnt1     = st_r.cnt + 1'h1;
          r        = ramp(cnt1, main_rate); // R24
          st_n.cnt = cnt1;
          st_n.pos = r;
          done     = st_r.tt == vtk_pkg::TT_CUT || r == FULL; // R8
        end
      end
      if (done) begin
        st_n.busy  = 1'h0;
        st_n.lvr   = 1'h0;
        st_n.pos   = ZERO;
        st_n.lhold = st_r.lvr;
        unique case (st_r.pb)
          vtk_pkg::PB_TO: st_n.pb = vtk_pkg::PB_HELD;
          vtk_pkg::PB_OFF, vtk_pkg::PB_HELD: fin = 1'h1;
          vtk_pkg::PB_FROM: begin
            fin     = 1'h1;
            st_n.pb = vtk_pkg::PB_OFF;
          end
        endcase
      end
      if (fin) begin
        st_n.con   = st_r.non;
        st_n.cprio = st_r.nprio; // R18
        if (st_r.nbg) begin
          st_n.sel_a = st_r.sel_b; // R11
          st_n.sel_b = st_r.sel_a; // R11
        end
      end
      if (frame_start && st_r.pend && !(fin && st_r.nbg)) begin
        st_n.sel_b = st_r.pend_sel; // R25
        st_n.pend  = 1'h0;
      end
      if (preset_ld) begin
        st_n.pend     = 1'h1;
        st_n.pend_sel = preset_sel;
      end
      for (int k = 0; k < NKEY; k++) begin
        cnt1 = st_r.kcnt[k*RW+:RW] + 1'h1;
        r    = ramp(cnt1, key_rate[k*RW+:RW]);
        if (key_mix_go[k] && !st_r.kbusy[k]) begin
          st_n.kbusy[k]            = 1'h1; // R10
          st_n.kdir[k]             = !st_n.con[k];
          st_n.kcnt[k*RW+:RW]      = '0;
          st_n.klvl[k*PSW+:PSW]    = st_n.con[k] ? FULL : ZERO;
        end else if (frame_start && st_r.kbusy[k]) begin
          st_n.kcnt[k*RW+:RW]      = cnt1;
          st_n.klvl[k*PSW+:PSW]    = st_r.kdir[k] ? r : FULL - r; // R10
          if (r == FULL) begin
            st_n.kbusy[k] = 1'h0;
            st_n.con[k]   = st_r.kdir[k];
          end
        end
      end
      cnt1 = st_r.fcnt + 1'h1;
      r    = ramp(cnt1, ftb_rate);
      if (ftb_go && !st_r.fbusy && st_r.opt == vtk_pkg::OPT_DSTAGE) begin
        st_n.fbusy = 1'h1;
        st_n.fdir  = st_r.fpos == ZERO;
        st_n.fcnt  = '0;
      end else if (frame_start && st_r.fbusy) begin
        st_n.fcnt = cnt1;
        st_n.fpos = st_r.fdir ? r : FULL - r; // R7
        st_n.fbusy = r != FULL;
      end
      if (frame_start && !st_r.busy && !start && !st_r.fbusy && opt_req != vtk_pkg::OPT_BAD) begin
        st_n.opt = opt_req; // R20
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r       <= '0;
      st_r.cprio <= vtk_pkg::PRIO_RST;
    end else begin
      st_r <= st_n;
    end
  end

  assign in_ready   = st_r.rdy;
  assign out_valid  = st_r.ov;
  assign pgm_pix    = st_r.h0[3*PW-1-:PW];
  assign pvw_pix    = st_r.h0[2*PW-1-:PW];
  assign aux_pix    = st_r.h0[PW-1:0];
  assign trans_busy = st_r.busy;
  assign on_black   = st_r.pb == vtk_pkg::PB_HELD;
  assign opt_mode   = st_r.opt;
  assign ftb_level  = st_r.fpos;
  assign bus_a_sel  = st_r.sel_a;
  assign bus_b_sel  = st_r.sel_b;
  assign key_on     = st_r.con;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_RATE_DONE: assert property ( // R24
    ce && frame_start && st_r.busy && !st_r.lvr && main_rate != '0 && st_r.cnt + 1'h1 == main_rate
    |=> !st_r.busy && st_r.pos == ZERO)
    else $error("timed transition did not end on its last frame");
  AST_FLIP: assert property ( // R11
    $fell(st_r.busy) && $past(st_r.nbg) && $past(st_r.pb) != vtk_pkg::PB_TO
    |-> st_r.sel_a == $past(st_r.sel_b) && st_r.sel_b == $past(st_r.sel_a))
    else $error("background buses not swapped at end");
  AST_SEL_FRAME: assert property ( // R25
    !(ce && frame_start) |=> $stable(st_r.sel_b) && $stable(st_r.sel_a))
    else $error("bus selection changed off a frame boundary");
  AST_OPT_EXCL: assert property ( // R20
    st_r.opt != vtk_pkg::OPT_BAD)
    else $error("half stage and downstream stage both active");
  AST_ADD_CLIP: assert property ( // R2
    st_r.busy && st_r.tt == vtk_pkg::TT_ADD && cur_c == WHITE && nxt_c == WHITE |-> mixed == WHITE)
    else $error("additive sum not clipped at white");
  AST_PVW: assert property ( // R12
    ce && push && st_r.bcnt == 2'h0 && lookahead |=> st_r.h0[2*PW-1-:PW] == $past(nxt_c))
    else $error("look-ahead preview is not the next stack");
  AST_PB_BLACK: assert property ( // R6
    st_r.pb == vtk_pkg::PB_HELD && !st_r.busy |-> layered == BLACK)
    else $error("picture not black while preset black held");
  AST_KMIX: assert property ( // R10
    ce && key_mix_go[0] && !st_r.kbusy[0] |=> st_r.kbusy[0] && st_r.kdir[0] != st_r.con[0])
    else $error("key mix did not start");
  AST_HALF: assert property ( // R19
    st_r.opt == vtk_pkg::OPT_HALF && st_r.busy |-> st_r.tt == vtk_pkg::TT_CUT || st_r.tt == vtk_pkg::TT_MIX)
    else $error("half stage ran a wipe or additive");
  AST_FTB: assert property ( // R7
    st_r.opt == vtk_pkg::OPT_DSTAGE && st_r.fpos == FULL |-> pgm_c == BLACK)
    else $error("program not black after fade to black");

endmodule : vtk_me_stage

// ==== vtk_pix_partner.sv ====
// Pixel source and output sink facing the stage stream ports
`timescale 1ns/1ps
module vtk_pix_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Bench controls
  input  wire logic [31:0] n_req,
  input  wire logic [31:0] word,
  input  wire logic        stall,
  // Stage stream
  input  wire logic        in_ready,
  input  wire logic        out_valid,
  output logic             in_valid,
  output logic [31:0]      src_pix,
  output logic             out_ready,
  output int               n_acc,
  output int               n_pop
);
  // Holds each word until in_ready is sampled high; idle data toggles every cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_valid  <= 1'b0;
      src_pix   <= 32'h0;
      out_ready <= 1'b0;
      n_acc     <= 0;
      n_pop     <= 0;
    end else begin
      if (in_valid && in_ready) n_acc <= n_acc + 1;
      if (out_valid && out_ready) n_pop <= n_pop + 1;
      if (!in_valid || in_ready) begin
        in_valid <= (n_acc + ((in_valid && in_ready) ? 1 : 0)) < n_req;
        src_pix  <= ((n_acc + ((in_valid && in_ready) ? 1 : 0)) < n_req) ? word : ~src_pix;
      end
      out_ready <= !stall;
    end
  end
endmodule : vtk_pix_partner

// ==== vtk_pkg.sv ====
// Constants and types for the mix-effects transition and keying stage
package vtk_pkg;

  localparam int          PIX_W     = 8;
  localparam int          NKEY      = 4;
  localparam int          NSRC      = 4;
  localparam int          RATE_W    = 8;
  localparam int          POS_W     = 9;
  localparam logic [8:0]  POS_FULL  = 9'h100;
  localparam logic [8:0]  POS_HALF  = 9'h080;
  localparam logic [8:0]  POS_ZERO  = 9'h000;
  localparam logic [7:0]  PIX_WHITE = 8'hff;
  localparam logic [7:0]  PIX_BLACK = 8'h00;
  localparam logic [7:0]  PIX_MID   = 8'h80;
  localparam logic [7:0]  PRIO_RST  = 8'he4;
  localparam logic [1:0]  BUF_DEPTH = 2'h2;

  // Wipe pattern shapes
  localparam logic [1:0]  WP_HORZ   = 2'h0;
  localparam logic [1:0]  WP_VERT   = 2'h1;
  localparam logic [1:0]  WP_BOX    = 2'h2;
  localparam logic [1:0]  WP_DIAG   = 2'h3;

  // Combining of the two transition wipes
  localparam logic [1:0]  WC_ONE    = 2'h0;
  localparam logic [1:0]  WC_OR     = 2'h1;
  localparam logic [1:0]  WC_AND    = 2'h2;
  localparam logic [1:0]  WC_XOR    = 2'h3;

  // Key mask modes
  localparam logic [1:0]  MK_NONE   = 2'h0;
  localparam logic [1:0]  MK_INH_S  = 2'h1;
  localparam logic [1:0]  MK_INH_B  = 2'h2;
  localparam logic [1:0]  MK_FRC_B  = 2'h3;

  typedef enum logic [1:0] {
    TT_CUT = 2'b00, TT_MIX = 2'b01, TT_ADD = 2'b10, TT_WIPE = 2'b11
  } vtk_trans_t;

  typedef enum logic [1:0] {
    PB_OFF = 2'b00, PB_TO = 2'b01, PB_HELD = 2'b10, PB_FROM = 2'b11
  } vtk_pb_t;

  typedef enum logic [1:0] {
    OPT_NONE = 2'b00, OPT_DSTAGE = 2'b01, OPT_HALF = 2'b10, OPT_BAD = 2'b11
  } vtk_opt_t;

endpackage : vtk_pkg
